// ---- design/ipsp_pkg.sv ----
// Constants, pulse types and helpers for the pulse-link serial port.
// Assumes a 25 MHz core clock and a separate free link clock.
package ipsp_pkg;
	typedef enum logic [1:0] {
		IPSP_LONG_POS,
		IPSP_LONG_NEG,
		IPSP_SHORT_POS,
		IPSP_SHORT_NEG
	} ipsp_pulse_t;

	localparam int CORE_CLK_NS     = 40;
	localparam int LINK_CLK_NS     = 15;
	localparam int HALF_LONG_NS    = 150;
	localparam int HALF_SHORT_NS   = 50;
	localparam int LONG_MIN_NS     = 100;
	localparam int RET_WINDOW_NS   = 600;
	localparam int WAKE_DWELL_NS   = 240;
	localparam int BLACKOUT_NS     = 10000;
	localparam int IDLE_TIMEOUT_NS = 4000000;
	localparam int WAKE_TIME_NS    = 400000;
	localparam int READY_TIME_NS   = 10000;
	localparam int CMD_BITS        = 32;
	localparam int CNT_W           = 24;
	localparam int LCNT_W          = 8;
	localparam int DW_W            = 4;
	localparam int BIT_W           = 6;

	// Least times round up
	function automatic int cyc_ceil(input int ns, input int per);
		return (ns + per - 1) / per;
	endfunction : cyc_ceil

	// Longest times round down, never below one cycle
	function automatic int cyc_floor(input int ns, input int per);
		return (ns / per < 1) ? 1 : ns / per;
	endfunction : cyc_floor

	function automatic ipsp_pulse_t pulse_of(input logic lng, input logic pos);
		case ({lng, pos})
		2'h3: return IPSP_LONG_POS;
		2'h2: return IPSP_LONG_NEG;
		2'h1: return IPSP_SHORT_POS;
		default: return IPSP_SHORT_NEG;
		endcase
	endfunction : pulse_of

	function automatic logic is_long(input ipsp_pulse_t p);
		return (p == IPSP_LONG_POS) || (p == IPSP_LONG_NEG);
	endfunction : is_long
endpackage : ipsp_pkg

// ---- design/ipsp_phy.sv ----
// Pulse encoder and decoder for one differential port, link clock domain.
// Assumes comparator levels on the pair inputs and stable tx type on toggle.
`timescale 1ns/1ps
module ipsp_phy (
	// Link clock and reset
	input  wire logic            lclk_i,
	input  wire logic            lrst_i,
	// Pair comparator levels and drive
	input  wire logic            rx_pos_i,
	input  wire logic            rx_neg_i,
	output logic                 tx_pos_o,
	output logic                 tx_neg_o,
	output logic                 tx_oe_o,
	// Requests from the core side
	input  wire logic            tx_tgl_i,
	input  ipsp_pkg::ipsp_pulse_t tx_type_i,
	input  wire logic            slave_i,
	input  wire logic            reply_zero_i,
	// Events to the core side
	output logic                 rx_tgl_o,
	output ipsp_pkg::ipsp_pulse_t rx_type_o,
	output logic                 ret_tgl_o,
	output logic                 ret_bit_o,
	output logic                 done_tgl_o
);
	import ipsp_pkg::*;

	localparam int SH_CYC = cyc_ceil(HALF_SHORT_NS, LINK_CLK_NS);
	localparam int LG_CYC = cyc_ceil(HALF_LONG_NS, LINK_CLK_NS);
	localparam int LM_CYC = cyc_ceil(LONG_MIN_NS, LINK_CLK_NS);
	localparam int RW_CYC = cyc_floor(RET_WINDOW_NS, LINK_CLK_NS);

	typedef enum logic [1:0] {R_IDLE, R_FIRST, R_SECOND} ipsp_rx_t;
	typedef enum logic [1:0] {T_IDLE, T_FIRST, T_SECOND, T_LISTEN} ipsp_tx_t;

	logic              pos_s1, pos_s2, neg_s1, neg_s2;
	ipsp_rx_t          rst, next_rst;
	ipsp_tx_t          tst, next_tst;
	logic              rpol, next_rpol, rlong, next_rlong;
	logic [LCNT_W-1:0] rcnt, next_rcnt, tcnt, next_tcnt;
	ipsp_pulse_t       ttype, next_ttype, next_rx_type;
	logic              tseen, next_tseen, next_rx_tgl, next_ret_tgl, next_ret_bit;
	logic              next_done_tgl, next_pos, next_neg, next_oe;
	logic              rx_ev, busy, start, lvl_a, lvl_b, pfirst;
	ipsp_pulse_t       rx_evt, start_t;
	logic [LCNT_W-1:0] half;

	always_ff @(posedge lclk_i) begin
		pos_s1 <= rx_pos_i;
		pos_s2 <= pos_s1;
		neg_s1 <= rx_neg_i;
		neg_s2 <= neg_s1;
	end

	always_comb begin
		next_rst = rst; next_rpol = rpol; next_rlong = rlong; next_rcnt = rcnt;
		next_rx_tgl = rx_tgl_o; next_rx_type = rx_type_o;
		rx_ev = 1'h0; rx_evt = IPSP_SHORT_NEG;
		busy = (tst == T_FIRST) || (tst == T_SECOND);
		lvl_a = rpol ? pos_s2 : neg_s2;
		lvl_b = rpol ? neg_s2 : pos_s2;
		// Own drive echoes on the comparators, so decoding waits it out
		case (rst)
		R_IDLE: if (!busy && (pos_s2 ^ neg_s2)) begin
			next_rst = R_FIRST; next_rpol = pos_s2; next_rcnt = '0;
		end
		R_FIRST: if (lvl_a && !lvl_b) begin
			if (rcnt != '1) next_rcnt = rcnt + 1'h1;
		end else if (lvl_b) begin
			next_rst = R_SECOND; next_rlong = (rcnt >= LCNT_W'(LM_CYC - 1));
		end else next_rst = R_IDLE;
		R_SECOND: if (!lvl_b) begin
			next_rst = R_IDLE; rx_ev = 1'h1; rx_evt = pulse_of(rlong, rpol);
			next_rx_tgl = ~rx_tgl_o; next_rx_type = rx_evt;
		end
		default: next_rst = R_IDLE;
		endcase

		next_tst = tst; next_tcnt = tcnt; next_ttype = ttype; next_tseen = tseen;
		next_ret_tgl = ret_tgl_o; next_ret_bit = ret_bit_o; next_done_tgl = done_tgl_o;
		start = 1'h0; start_t = IPSP_SHORT_NEG;
		half = is_long(ttype) ? LCNT_W'(LG_CYC - 1) : LCNT_W'(SH_CYC - 1);
		case (tst)
		T_IDLE: if (tx_tgl_i != tseen) begin
			next_tseen = tx_tgl_i;
			start = !slave_i; start_t = tx_type_i;
		end else if (rx_ev && slave_i && reply_zero_i && !is_long(rx_evt)) begin
			start = 1'h1; start_t = IPSP_SHORT_NEG;
		end
		T_FIRST: if (tcnt == half) begin
			next_tst = T_SECOND; next_tcnt = '0;
		end else next_tcnt = tcnt + 1'h1;
		T_SECOND: if (tcnt == half) begin
			next_done_tgl = ~done_tgl_o; next_tcnt = '0;
			next_tst = (!slave_i && !is_long(ttype)) ? T_LISTEN : T_IDLE;
		end else next_tcnt = tcnt + 1'h1;
		T_LISTEN: if (rx_ev && rx_evt == IPSP_SHORT_NEG) begin
			next_tst = T_IDLE; next_ret_bit = 1'h0; next_ret_tgl = ~ret_tgl_o;
		end else if (tcnt == LCNT_W'(RW_CYC - 1)) begin
			next_tst = T_IDLE; next_ret_bit = 1'h1; next_ret_tgl = ~ret_tgl_o;
		end else next_tcnt = tcnt + 1'h1;
		default: next_tst = T_IDLE;
		endcase
		if (start) begin
			next_tst = T_FIRST; next_tcnt = '0; next_ttype = start_t;
		end
		pfirst = (next_ttype == IPSP_LONG_POS) || (next_ttype == IPSP_SHORT_POS);
		next_oe = (next_tst == T_FIRST) || (next_tst == T_SECOND);
		next_pos = next_oe && ((next_tst == T_FIRST) == pfirst);
		next_neg = next_oe && !next_pos;
	end

	always_ff @(posedge lclk_i) begin
		if (lrst_i) begin
			rst <= R_IDLE; rpol <= 1'h0; rlong <= 1'h0; rcnt <= '0;
			tst <= T_IDLE; tcnt <= '0; ttype <= IPSP_SHORT_NEG; tseen <= 1'h0;
			rx_tgl_o <= 1'h0; rx_type_o <= IPSP_SHORT_NEG;
			ret_tgl_o <= 1'h0; ret_bit_o <= 1'h1; done_tgl_o <= 1'h0;
			tx_pos_o <= 1'h0; tx_neg_o <= 1'h0; tx_oe_o <= 1'h0;
		end else begin
			rst <= next_rst; rpol <= next_rpol; rlong <= next_rlong; rcnt <= next_rcnt;
			tst <= next_tst; tcnt <= next_tcnt; ttype <= next_ttype; tseen <= next_tseen;
			rx_tgl_o <= next_rx_tgl; rx_type_o <= next_rx_type;
			ret_tgl_o <= next_ret_tgl; ret_bit_o <= next_ret_bit;
			done_tgl_o <= next_done_tgl;
			tx_pos_o <= next_pos; tx_neg_o <= next_neg; tx_oe_o <= next_oe;
		end
	end
endmodule : ipsp_phy

// ---- design/ipsp_port.sv ----
// Port logic of a daisy-chained monitor: SPI or pulse link on port A,
// pulse link on port B, role selection, swap, idle and wake handling.
// Assumes the core reacts to the internal SPI signals on clk_i and that
// link_clk_i runs freely; pulse shaping sits in ipsp_phy on that clock.
`timescale 1ns/1ps

// Notes on behaviour
// - SPI mode: select edges give long pulses, rising clock edges short by data bit.
// - Slave port turns long pulses into select, short ones into data and clock in the same cycle.
// - While reading, slave answers a short pulse with short -1 for a 0 bit only.
// - A slave port sends no long pulses and only short -1 pulses.
// - Master reads a missing answer in a read slot as 1.
// - Mode strap: low gives SPI port A with B master, high gives pulse port A.
// - In ready, port getting long -1 is slave, the other master and forwards.
// - Asleep, valid wake on either port wakes it in both modes.
// - Wake from A sends long +1 on B once up; wake from B sends nothing.
// - Active holds select low; long +1 on slave ends and returns to ready.
// - Active, long -1 on master swaps roles; sender waits out the blackout.
// - Long pulses on master within blackout of last transmission are ignored.
// - After 32 command and checksum bits the read is decoded for next clock.
// - Bottom device returns its own data first, then data from above.
// - No activity on either port for the idle timeout sends ports idle.
// - SPI mode wakes on select or clock; pulse mode on differential only.
// - Wake needs the threshold held for the dwell time; ready after wake or ready time.
// - A device already awake does not pass a wake pulse upward.
// - Pulses are two opposite halves, 150 ns long type, 50 ns short type.
// - Whole bytes, MSB first; select held for the whole command.
module ipsp_port #(
	parameter int IDLE_CYC = ipsp_pkg::cyc_ceil(ipsp_pkg::IDLE_TIMEOUT_NS,
		ipsp_pkg::CORE_CLK_NS),
	parameter int WAKE_CYC = ipsp_pkg::cyc_floor(ipsp_pkg::WAKE_TIME_NS,
		ipsp_pkg::CORE_CLK_NS)
) (
	// Clocks and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic link_clk_i,
	// Mode strap
	input  wire logic port_a_mode_select_i,
	// Port A four-wire pins
	input  wire logic chip_select_n_i,
	input  wire logic sck_i,
	input  wire logic sdi_i,
	output logic      sdo_o,
	// Port A pair
	input  wire logic port_a_pair_pos_i,
	input  wire logic port_a_pair_neg_i,
	output logic      port_a_pair_pos_o,
	output logic      port_a_pair_neg_o,
	output logic      port_a_pair_oe_o,
	// Port B pair
	input  wire logic port_b_pair_pos_i,
	input  wire logic port_b_pair_neg_i,
	output logic      port_b_pair_pos_o,
	output logic      port_b_pair_neg_o,
	output logic      port_b_pair_oe_o,
	// Core side
	input  wire logic core_standby_i,
	input  wire logic read_mode_i,
	input  wire logic own_data_i,
	input  wire logic own_bit_i,
	output logic      int_chip_select_n_o,
	output logic      int_sck_o,
	output logic      int_sdi_o,
	output logic      cmd_done_o,
	// Status
	output logic      awake_o,
	output logic      active_o,
	output logic      slave_is_b_o
);
	import ipsp_pkg::*;

	localparam int RDY_CYC = cyc_floor(READY_TIME_NS, CORE_CLK_NS);
	localparam int BLK_CYC = cyc_ceil(BLACKOUT_NS, CORE_CLK_NS);
	localparam int DW_CYC  = cyc_ceil(WAKE_DWELL_NS, CORE_CLK_NS);

	typedef enum logic [1:0] {S_IDLE, S_WAKE, S_READY, S_ACTIVE} ipsp_state_t;

	// Pin synchronisers
	logic [7:0] pin_s1, pin_s2;
	logic       mode, csn, sck, sdi, apos, aneg, bpos, bneg;

	// Link side crossing
	logic       lrst_s1, lrst;
	logic [4:0] l_s1, l_s2;
	logic [5:0] tg_l, tg_s1, tg_s2, tg_s3, ev;
	ipsp_pulse_t rxt_a, rxt_b;
	logic       rb_a, rb_b;

	// Core state
	ipsp_state_t      st, next_st;
	logic             from_a, next_from_a, slv_b, next_slv_b;
	logic [CNT_W-1:0] tmr, next_tmr, idle, next_idle, blk, next_blk;
	logic [1:0]       tx_tgl, next_tx_tgl, slv_lv, next_slv_lv;
	ipsp_pulse_t      tx_type, next_tx_type;
	logic             pend, next_pend, csn_q, next_csn_q, sck_q, next_sck_q;
	logic             next_icsn, next_isck, next_isdi, next_done;
	logic [BIT_W-1:0] bits, next_bits;
	logic             mret, next_mret, rz, next_rz, next_sdo;
	logic             next_awake, next_active;
	logic             iss, act, bit_out, spi_act, s_ev, m_ev, m_ret, m_rb;
	ipsp_pulse_t      ity, s_ty, m_ty;

	// Wake detection
	logic [DW_W-1:0]  dwa, dwb, next_dwa, next_dwb;
	logic             wake_a, wake_b;

	function automatic logic [DW_W-1:0] dwell(input logic [DW_W-1:0] c,
		input logic lvl);
		if (!lvl)
			return '0;
		return (c == DW_W'(DW_CYC)) ? c : c + 1'h1;
	endfunction : dwell

	always_ff @(posedge clk_i) begin
		pin_s1 <= {port_a_mode_select_i, chip_select_n_i, sck_i, sdi_i,
			port_a_pair_pos_i, port_a_pair_neg_i, port_b_pair_pos_i, port_b_pair_neg_i};
		pin_s2 <= pin_s1;
		tg_s1  <= tg_l;
		tg_s2  <= tg_s1;
		tg_s3  <= tg_s2;
	end

	assign {mode, csn, sck, sdi, apos, aneg, bpos, bneg} = pin_s2;
	assign ev = tg_s2 ^ tg_s3;

	// Reset and control levels into the link domain; tx_type is held while pending
	always_ff @(posedge link_clk_i) begin
		lrst_s1 <= sys_rst_i;
		lrst    <= lrst_s1;
		l_s1    <= {rz, slv_lv, tx_tgl};
		l_s2    <= l_s1;
	end

	ipsp_phy u_phy_a (
		.lclk_i       (link_clk_i),
		.lrst_i       (lrst),
		.rx_pos_i     (port_a_pair_pos_i),
		.rx_neg_i     (port_a_pair_neg_i),
		.tx_pos_o     (port_a_pair_pos_o),
		.tx_neg_o     (port_a_pair_neg_o),
		.tx_oe_o      (port_a_pair_oe_o),
		.tx_tgl_i     (l_s2[0]),
		.tx_type_i    (tx_type),
		.slave_i      (l_s2[2]),
		.reply_zero_i (l_s2[4]),
		.rx_tgl_o     (tg_l[0]),
		.rx_type_o    (rxt_a),
		.ret_tgl_o    (tg_l[2]),
		.ret_bit_o    (rb_a),
		.done_tgl_o   (tg_l[4])
	);

	ipsp_phy u_phy_b (
		.lclk_i       (link_clk_i),
		.lrst_i       (lrst),
		.rx_pos_i     (port_b_pair_pos_i),
		.rx_neg_i     (port_b_pair_neg_i),
		.tx_pos_o     (port_b_pair_pos_o),
		.tx_neg_o     (port_b_pair_neg_o),
		.tx_oe_o      (port_b_pair_oe_o),
		.tx_tgl_i     (l_s2[1]),
		.tx_type_i    (tx_type),
		.slave_i      (l_s2[3]),
		.reply_zero_i (l_s2[4]),
		.rx_tgl_o     (tg_l[1]),
		.rx_type_o    (rxt_b),
		.ret_tgl_o    (tg_l[3]),
		.ret_bit_o    (rb_b),
		.done_tgl_o   (tg_l[5])
	);

	// Common-mode swings show on both comparators and are not counted
	always_comb begin
		next_dwa = dwell(dwa, apos ^ aneg);
		next_dwb = dwell(dwb, bpos ^ bneg);
		spi_act  = (csn != csn_q) || (sck != sck_q);
		wake_a   = mode ? (dwa == DW_W'(DW_CYC)) : spi_act;
		wake_b   = (dwb == DW_W'(DW_CYC));
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dwa <= '0;
			dwb <= '0;
		end else begin
			dwa <= next_dwa;
			dwb <= next_dwb;
		end
	end

	always_comb begin
		next_st = st; next_from_a = from_a; next_slv_b = slv_b; next_tmr = tmr;
		next_idle = idle; next_blk = (blk != '0) ? blk - 1'h1 : blk;
		next_tx_tgl = tx_tgl; next_tx_type = tx_type; next_pend = pend;
		next_icsn = int_chip_select_n_o; next_isck = 1'h0; next_isdi = int_sdi_o;
		next_bits = bits; next_done = 1'h0; next_mret = mret;
		next_csn_q = csn; next_sck_q = sck;
		iss = 1'h0; act = 1'h0; ity = IPSP_LONG_POS;
		s_ev = slv_b ? ev[1] : ev[0];
		s_ty = slv_b ? rxt_b : rxt_a;
		m_ev = slv_b ? ev[0] : ev[1];
		m_ty = slv_b ? rxt_a : rxt_b;
		m_ret = slv_b ? ev[2] : ev[3];
		m_rb = slv_b ? rb_a : rb_b;

		// Any transmission on either port restarts the blackout
		if (|ev[5:4]) begin
			next_pend = 1'h0;
			next_blk = CNT_W'(BLK_CYC);
		end
		if (m_ret)
			next_mret = m_rb;

		case (st)
		S_IDLE: if (wake_a || wake_b) begin
			next_st = S_WAKE; next_from_a = wake_a; next_tmr = '0;
		end
		S_WAKE: begin
			next_tmr = tmr + 1'h1;
			if (tmr >= CNT_W'((core_standby_i ? RDY_CYC : WAKE_CYC) - 1)) begin
				next_st = S_READY; next_slv_b = 1'h0; next_idle = '0;
				iss = from_a; ity = IPSP_LONG_POS;
			end
		end
		S_READY, S_ACTIVE: if (!mode) begin
			next_slv_b = 1'h0;
			if (csn_q && !csn) begin
				next_st = S_ACTIVE; next_icsn = 1'h0; next_bits = '0;
				iss = 1'h1; ity = IPSP_LONG_NEG; act = 1'h1;
			end else if (!csn_q && csn) begin
				next_st = S_READY; next_icsn = 1'h1;
				iss = 1'h1; ity = IPSP_LONG_POS; act = 1'h1;
			end else if (!sck_q && sck && !csn) begin
				next_isdi = sdi; next_isck = 1'h1;
				iss = 1'h1; ity = pulse_of(1'h0, sdi); act = 1'h1;
			end
		end else if (st == S_READY) begin
			if (ev[0] && rxt_a == IPSP_LONG_NEG) begin
				next_slv_b = 1'h0; next_st = S_ACTIVE; next_icsn = 1'h0;
				next_bits = '0; iss = 1'h1; ity = IPSP_LONG_NEG; act = 1'h1;
			end else if (ev[1] && rxt_b == IPSP_LONG_NEG) begin
				next_slv_b = 1'h1; next_st = S_ACTIVE; next_icsn = 1'h0;
				next_bits = '0; iss = 1'h1; ity = IPSP_LONG_NEG; act = 1'h1;
			end
		end else if (s_ev) begin
			act = 1'h1;
			if (s_ty == IPSP_LONG_POS) begin
				next_st = S_READY; next_icsn = 1'h1;
				iss = 1'h1; ity = IPSP_LONG_POS;
			end else if (!is_long(s_ty)) begin
				next_isdi = (s_ty == IPSP_SHORT_POS); next_isck = 1'h1;
				iss = 1'h1; ity = s_ty;
			end
		end else if (m_ev && m_ty == IPSP_LONG_NEG && blk == '0) begin
			next_slv_b = ~slv_b; act = 1'h1;
			iss = 1'h1; ity = IPSP_LONG_NEG;
		end
		default: next_st = S_IDLE;
		endcase

		if (st == S_READY || st == S_ACTIVE) begin
			if (act)
				next_idle = '0;
			else if (idle >= CNT_W'(IDLE_CYC - 1)) begin
				next_st = S_IDLE; next_icsn = 1'h1; iss = 1'h0;
			end else
				next_idle = idle + 1'h1;
		end

		// Only the master port is ever asked to send; one pulse at a time
		if (iss && !pend) begin
			next_pend = 1'h1;
			next_tx_type = ity;
			if (next_slv_b)
				next_tx_tgl[0] = ~tx_tgl[0];
			else
				next_tx_tgl[1] = ~tx_tgl[1];
		end

		// Select stays low across the whole command; bits only counted inside it
		if (next_isck && !next_icsn && bits != BIT_W'(CMD_BITS)) begin
			next_bits = bits + 1'h1;
			next_done = (bits == BIT_W'(CMD_BITS - 1));
		end

		bit_out = own_data_i ? own_bit_i : mret;
		next_rz = mode && read_mode_i && !bit_out && (next_st == S_ACTIVE);
		next_sdo = csn ? 1'h1 : bit_out;
		next_awake = (next_st == S_READY) || (next_st == S_ACTIVE);
		next_active = (next_st == S_ACTIVE);
		next_slv_lv = {mode && next_awake && next_slv_b,
			mode && next_awake && !next_slv_b};
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= S_IDLE; from_a <= 1'h0; slv_b <= 1'h0;
			tmr <= '0; idle <= '0; blk <= '0;
			tx_tgl <= '0; tx_type <= IPSP_LONG_POS; pend <= 1'h0;
			csn_q <= 1'h1; sck_q <= 1'h0; bits <= '0; mret <= 1'h1;
			rz <= 1'h0; slv_lv <= '0;
			int_chip_select_n_o <= 1'h1; int_sck_o <= 1'h0; int_sdi_o <= 1'h0;
			cmd_done_o <= 1'h0; sdo_o <= 1'h1;
			awake_o <= 1'h0; active_o <= 1'h0;
		end else begin
			st <= next_st; from_a <= next_from_a; slv_b <= next_slv_b;
			tmr <= next_tmr; idle <= next_idle; blk <= next_blk;
			tx_tgl <= next_tx_tgl; tx_type <= next_tx_type; pend <= next_pend;
			csn_q <= next_csn_q; sck_q <= next_sck_q; bits <= next_bits;
			mret <= next_mret; rz <= next_rz; slv_lv <= next_slv_lv;
			int_chip_select_n_o <= next_icsn; int_sck_o <= next_isck;
			int_sdi_o <= next_isdi; cmd_done_o <= next_done; sdo_o <= next_sdo;
			awake_o <= next_awake; active_o <= next_active;
		end
	end

	assign slave_is_b_o = slv_b;
endmodule : ipsp_port

// ---- tb/ipsp_link_model.sv ----
// Far-side pulse partner: decodes pulses driven on a pair, sends pulses.
// Assumes it runs on the same link clock as the port logic.
`timescale 1ns/1ps
module ipsp_link_model (
	// Link clock
	input  wire logic lclk_i,
	// Drive seen from the port
	input  wire logic tx_pos_i,
	input  wire logic tx_neg_i,
	input  wire logic tx_oe_i,
	// Answer each short pulse with a short -1
	input  wire logic reply_i,
	// Comparator levels to the port
	output logic      rx_pos_o,
	output logic      rx_neg_o
);
	import ipsp_pkg::*;
	ipsp_pulse_t last   = IPSP_SHORT_NEG;
	int          npulse = 0;
	int          cnt    = 0;
	logic        busy   = 1'b0;
	logic        pol    = 1'b0;
	initial begin
		rx_pos_o = 1'b0;
		rx_neg_o = 1'b0;
	end
	// Two opposite halves, then the terminated pair rests at 0 V
	task automatic send(input logic lng, input logic pos);
		int n;
		n = lng ? 10 : 4;
		@(posedge lclk_i);
		{rx_pos_o, rx_neg_o} <= {pos, !pos};
		repeat (n) @(posedge lclk_i);
		{rx_pos_o, rx_neg_o} <= {!pos, pos};
		repeat (n) @(posedge lclk_i);
		{rx_pos_o, rx_neg_o} <= 2'h0;
	endtask : send
	// Length of the first half tells long from short
	always @(posedge lclk_i) begin
		if (tx_oe_i && (tx_pos_i ^ tx_neg_i)) begin
			if (!busy) begin
				busy <= 1'b1;
				pol  <= tx_pos_i;
				cnt  <= 1;
			end else if (tx_pos_i == pol) begin
				cnt <= cnt + 1;
			end
		end else if (busy) begin
			busy   <= 1'b0;
			last   <= pulse_of(cnt >= 7, pol);
			npulse <= npulse + 1;
		end
	end
	// A slave answers a 0 bit with a short -1 only, never a long pulse
	always @(negedge busy) begin
		if (reply_i && cnt < 7)
			send(1'b0, 1'b0);
	end
endmodule : ipsp_link_model

// ---- tb/ipsp_port_properties.sv ----
// Port-level assertions for the pulse-link port, core clock domain.
// Assumes the bind below; link-side pulse shapes are judged by the bench.
`timescale 1ns/1ps
module ipsp_port_properties (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Pins
	input wire logic port_a_mode_select_i,
	input wire logic chip_select_n_i,
	input wire logic sck_i,
	input wire logic sdi_i,
	input wire logic sdo_o,
	// Core side and status
	input wire logic int_chip_select_n_o,
	input wire logic int_sck_o,
	input wire logic int_sdi_o,
	input wire logic cmd_done_o,
	input wire logic awake_o,
	input wire logic active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_active_sel: assert property (active_o |-> !int_chip_select_n_o)
		else $error("select not low while active");
	a_idle_sel_high: assert property (!awake_o |-> int_chip_select_n_o)
		else $error("select low while asleep");
	a_active_awake: assert property (active_o |-> awake_o)
		else $error("active while asleep");
	a_sel_follow: assert property (!port_a_mode_select_i && awake_o && !active_o
		&& $fell(chip_select_n_i) |-> ##[2:5] (active_o && !int_chip_select_n_o))
		else $error("select fall not taken");
	a_ready_rise: assert property (!port_a_mode_select_i && active_o
		&& $rose(chip_select_n_i) |-> ##[2:5] !active_o)
		else $error("select rise did not end transfer");
	a_sck_follow: assert property (!port_a_mode_select_i && active_o
		&& $rose(sck_i) |-> ##[2:4] int_sck_o)
		else $error("clock edge not passed on");
	a_sck_one: assert property (int_sck_o |=> !int_sck_o)
		else $error("internal clock pulse too long");
	a_sck_active: assert property (int_sck_o |-> active_o)
		else $error("internal clock outside transfer");
	a_sdi_match: assert property (int_sck_o && !port_a_mode_select_i
		|-> int_sdi_o == $past(sdi_i, 4))
		else $error("internal data differs from pin");
	a_sdo_high: assert property (!port_a_mode_select_i && chip_select_n_i[*6] |-> sdo_o)
		else $error("data out low while deselected");
	a_cmd_active: assert property (cmd_done_o |-> active_o)
		else $error("command done outside transfer");
	cover property ($rose(awake_o));
	cover property (cmd_done_o);
	cover property ($rose(active_o) && port_a_mode_select_i);
endmodule : ipsp_port_properties
bind ipsp_port ipsp_port_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.port_a_mode_select_i(port_a_mode_select_i), .chip_select_n_i(chip_select_n_i),
	.sck_i(sck_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .int_chip_select_n_o(int_chip_select_n_o),
	.int_sck_o(int_sck_o), .int_sdi_o(int_sdi_o), .cmd_done_o(cmd_done_o),
	.awake_o(awake_o), .active_o(active_o));

// ---- tb/test_isolated_pulse_serial_port.sv ----
// Self-checking bench for the pulse-link port in SPI and pulse modes.
// Assumes partner models on both pairs and shortened idle and wake counts.
`timescale 1ns/1ps
module test_isolated_pulse_serial_port;
	import ipsp_pkg::*;
	localparam int IDLE_N = 600;
	localparam int WAKE_N = 50;
	logic clk_i = 1'b0;
	logic lclk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b0;
	logic csn = 1'b1;
	logic sck = 1'b0;
	logic sdi = 1'b0;
	logic own_data = 1'b0;
	logic own_bit = 1'b0;
	logic reply_b = 1'b0;
	logic read_mode = 1'b0;
	logic a_p, a_n, b_p, b_n, a_po, a_no, a_oe, b_po, b_no, b_oe;
	logic sdo, isel, isck, isdi, done, awake, active, slave_b;
	logic last_sdi;
	logic b;
	int bad_count = 0;
	int cmp_count = 0;
	int done_n = 0;
	int n0, d0, i;
	always #20 clk_i = !clk_i;
	always #7.5 lclk = !lclk;
	ipsp_port #(.IDLE_CYC(IDLE_N), .WAKE_CYC(WAKE_N)) u_dut (.clk_i(clk_i), .sys_rst_i(rst),
		.link_clk_i(lclk), .port_a_mode_select_i(mode), .chip_select_n_i(csn), .sck_i(sck),
		.sdi_i(sdi), .sdo_o(sdo), .port_a_pair_pos_i(a_p), .port_a_pair_neg_i(a_n),
		.port_a_pair_pos_o(a_po), .port_a_pair_neg_o(a_no), .port_a_pair_oe_o(a_oe),
		.port_b_pair_pos_i(b_p), .port_b_pair_neg_i(b_n), .port_b_pair_pos_o(b_po),
		.port_b_pair_neg_o(b_no), .port_b_pair_oe_o(b_oe), .core_standby_i(1'b0),
		.read_mode_i(read_mode), .own_data_i(own_data), .own_bit_i(own_bit),
		.int_chip_select_n_o(isel), .int_sck_o(isck), .int_sdi_o(isdi), .cmd_done_o(done),
		.awake_o(awake), .active_o(active), .slave_is_b_o(slave_b));
	ipsp_link_model u_ma (.lclk_i(lclk), .tx_pos_i(a_po), .tx_neg_i(a_no), .tx_oe_i(a_oe),
		.reply_i(1'b0), .rx_pos_o(a_p), .rx_neg_o(a_n));
	ipsp_link_model u_mb (.lclk_i(lclk), .tx_pos_i(b_po), .tx_neg_i(b_no), .tx_oe_i(b_oe),
		.reply_i(reply_b), .rx_pos_o(b_p), .rx_neg_o(b_n));
	always @(posedge clk_i) begin
		if (isck)
			last_sdi <= isdi;
		if (done)
			done_n <= done_n + 1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	task automatic check_bit(input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : check_bit
	task automatic check_pulse(input ipsp_pulse_t exp, input ipsp_pulse_t got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : check_pulse
	function automatic int seen(input logic on_b);
		return on_b ? u_mb.npulse : u_ma.npulse;
	endfunction : seen
	function automatic ipsp_pulse_t exp_short(input logic bit_v);
		return bit_v ? IPSP_SHORT_POS : IPSP_SHORT_NEG;
	endfunction : exp_short
	// Waits a bounded time for a new pulse, then compares its type
	task automatic expect_pulse(input logic on_b, input int c0, input ipsp_pulse_t exp);
		for (int k = 0; k < 200 && seen(on_b) == c0; k++)
			tick(1);
		check_bit(1'b1, seen(on_b) != c0);
		check_pulse(exp, on_b ? u_mb.last : u_ma.last);
	endtask : expect_pulse
	task automatic spi_bit(input logic v);
		int c0;
		c0 = seen(1'b1);
		sdi = v;
		tick(6);
		sck = 1'b1;
		tick(6);
		sck = 1'b0;
		expect_pulse(1'b1, c0, exp_short(v));
		tick(20);
	endtask : spi_bit
	task automatic stop_test;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	initial begin
		#1000000;
		bad_count++;
		stop_test();
	end
	initial begin
		b = 1'($urandom(44685));
		tick(10);
		rst = 1'b0;
		tick(3);
		check_bit(1'b0, awake);
		n0 = seen(1'b1);
		sck = 1'b1;
		tick(2);
		sck = 1'b0;
		tick(WAKE_N + 20);
		check_bit(1'b1, awake);
		expect_pulse(1'b1, n0, IPSP_LONG_POS);
		$display("Test wake from port A done");
		n0 = seen(1'b1);
		csn = 1'b0;
		tick(6);
		check_bit(1'b0, isel);
		expect_pulse(1'b1, n0, IPSP_LONG_NEG);
		tick(10);
		d0 = done_n;
		for (i = 0; i < 32; i++)
			spi_bit(1'($urandom));
		check_bit(1'b1, done_n == d0 + 1);
		reply_b = 1'b1;
		spi_bit(1'b0);
		reply_b = 1'b0;
		check_bit(1'b0, sdo);
		spi_bit(1'b1);
		tick(10);
		check_bit(1'b1, sdo);
		own_data = 1'b1;
		own_bit = 1'($urandom);
		tick(4);
		check_bit(own_bit, sdo);
		own_data = 1'b0;
		n0 = seen(1'b1);
		csn = 1'b1;
		tick(8);
		check_bit(1'b0, active);
		expect_pulse(1'b1, n0, IPSP_LONG_POS);
		$display("Test SPI transfer done");
		tick(IDLE_N + 20);
		check_bit(1'b0, awake);
		$display("Test idle done");
		mode = 1'b1;
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
		tick(3);
		n0 = seen(1'b0);
		u_mb.send(1'b1, 1'b1);
		tick(WAKE_N + 20);
		check_bit(1'b1, awake);
		check_bit(1'b1, seen(1'b0) == n0);
		n0 = seen(1'b1);
		u_ma.send(1'b1, 1'b0);
		tick(10);
		check_bit(1'b1, active);
		check_bit(1'b0, slave_b);
		expect_pulse(1'b1, n0, IPSP_LONG_NEG);
		for (i = 0; i < 8; i++) begin
			b = 1'($urandom);
			n0 = seen(1'b1);
			u_ma.send(1'b0, b);
			tick(8);
			check_bit(b, last_sdi);
			expect_pulse(1'b1, n0, exp_short(b));
			tick(20);
		end
		// Slave reading a 0 bit answers on its own pair with a short -1
		read_mode = 1'b1;
		own_data = 1'b1;
		own_bit = 1'b0;
		tick(2);
		n0 = seen(1'b0);
		u_ma.send(1'b0, 1'b1);
		expect_pulse(1'b0, n0, IPSP_SHORT_NEG);
		read_mode = 1'b0;
		own_data = 1'b0;
		tick(20);
		u_mb.send(1'b1, 1'b0);
		tick(10);
		check_bit(1'b0, slave_b);
		tick(260);
		u_mb.send(1'b1, 1'b0);
		tick(12);
		check_bit(1'b1, slave_b);
		u_mb.send(1'b1, 1'b1);
		tick(12);
		check_bit(1'b0, active);
		$display("Test pulse mode and swap done");
		stop_test();
	end
endmodule : test_isolated_pulse_serial_port
